/* shared/aer_consts.vh */
// Constants for the advanced error reporting register bank.
// Assumes a 32-bit configuration access port with byte-address offsets.
`ifndef AER_CONSTS_VH
`define AER_CONSTS_VH

// Register byte offsets in configuration space.
`define AER_OFF_CAP_HDR      12'hfb4
`define AER_OFF_UNC_STATUS   12'hfb8
`define AER_OFF_UNC_MASK     12'hfbc
`define AER_OFF_UNC_SEVERITY 12'hfc0
`define AER_OFF_COR_STATUS   12'hfc4
`define AER_OFF_COR_MASK     12'hfc8
`define AER_OFF_CAP_CTRL     12'hfcc
`define AER_OFF_HDR_LOG0     12'hfd0
`define AER_OFF_HDR_LOG1     12'hfd4
`define AER_OFF_HDR_LOG2     12'hfd8
`define AER_OFF_HDR_LOG3     12'hfdc

// Capability header fields.
`define AER_CAP_ID           16'h0001
`define AER_CAP_VERSION      4'h1
`define AER_NEXT_CAP_OFFSET  12'h138

// Implemented bit positions.
`define AER_UNC_IMPL         32'h001f1030
`define AER_COR_IMPL         32'h000011c1

// Reset values.
`define AER_UNC_STATUS_RST   32'h00000000
`define AER_UNC_MASK_RST     32'h00000000
`define AER_UNC_SEV_RST      32'h00062030
`define AER_COR_STATUS_RST   32'h00000000
`define AER_COR_MASK_RST     32'h00000000
`define AER_FIRST_PTR_RST    5'h1f
`define AER_HDR_LOG_RST      32'h00000000
`define AER_ECRC_GEN_EN_RST  1'h0
`define AER_ECRC_CHK_EN_RST  1'h0

// Capability and control fields.
`define AER_CTRL_PTR_MSB     4
`define AER_CTRL_GEN_CAP     5
`define AER_CTRL_GEN_EN      6
`define AER_CTRL_CHK_CAP     7
`define AER_CTRL_CHK_EN      8
`define AER_ECRC_GEN_CAP     1'h1
`define AER_ECRC_CHK_CAP     1'h1

`endif

/* hdl/aer_bank.v */
// Advanced error reporting register bank for one switch port.
// Assumes synchronous single-cycle configuration accesses, one-cycle error
// pulses from the layer detectors, and a header bus valid with each pulse.
//
// Summary of operation
// - Uncorrectable bits 4 and 5 set on DL protocol and surprise down, W1C.
// - Bits 12, 16, 17 set on poisoned, unexpected completion, overflow.
// - Bits 18, 19, 20 set on malformed, ECRC error, unsupported request.
// - Bits 13 to 15 are reserved in status and mask; writes ignored.
// - Uncorrectable mask blocks reporting, pointer update and logging, not status.
// - Severity bit one reports fatal; defaults one at bits 4,5,13,17,18.
// - Correctable bits 0, 6, 7, 8, 12 set on detection, sticky W1C.
// - Correctable mask stops reporting but status still records the error.
// - Five-bit sticky first error pointer, default all ones.
// - ECRC generation capable reads one; generate only while bit 6 set.
// - ECRC checking capable reads one; checking off until enabled.
// - Check received ECRC only while sticky enable bit 8 is one.
// - Read-only header: ID 0001h, version 1h, next offset 138h.
// - Four header doublewords of the logged packet captured, first lowest.
`timescale 1ns/1ps
`include "aer_consts.vh"

module aer_bank (
    input  wire         i_clock,
    input  wire         i_resetn,
    input  wire         i_clock_en,
    // Configuration space access.
    input  wire [11:0]  i_cfg_addr,
    input  wire         i_cfg_wr,
    input  wire         i_cfg_rd,
    input  wire [3:0]   i_cfg_be,
    input  wire [31:0]  i_cfg_wdata,
    output reg  [31:0]  o_cfg_rdata,
    // Serial EEPROM or I2C preload of the writable fields.
    input  wire         i_load_wr,
    input  wire [11:0]  i_load_addr,
    input  wire [31:0]  i_load_data,
    // Error detection pulses, one bit per status position.
    input  wire [31:0]  i_unc_event,
    input  wire [31:0]  i_cor_event,
    input  wire [127:0] i_tlp_header,
    // Error messages toward the message generator.
    output reg          o_report_fatal,
    output reg          o_report_nonfatal,
    output reg          o_report_correctable,
    // ECRC controls toward the transaction layer.
    output wire         o_ecrc_gen_en,
    output wire         o_ecrc_check_en
);

    ////////////////////////////////////////////////////////////////////////
    // State and decode.

    reg  [31:0] unc_status_reg;
    reg  [31:0] unc_mask_reg;
    reg  [31:0] unc_sev_reg;
    reg  [31:0] cor_status_reg;
    reg  [31:0] cor_mask_reg;
    reg  [4:0]  first_ptr_reg;
    reg         ecrc_gen_en_reg;
    reg         ecrc_chk_en_reg;
    reg  [31:0] hdr_log0_reg;
    reg  [31:0] hdr_log1_reg;
    reg  [31:0] hdr_log2_reg;
    reg  [31:0] hdr_log3_reg;

    reg  [31:0] unc_status_next;
    reg  [31:0] cor_status_next;
    reg  [4:0]  first_ptr_next;
    reg  [4:0]  low_pos;
    reg         low_found;
    integer     idx;

    wire [31:0] be_mask;
    wire [31:0] unc_new;
    wire [31:0] unc_unmasked;
    wire [31:0] cor_unmasked;
    wire        cfg_we;
    wire        log_take;
    wire [31:0] ctrl_value;
    wire [31:0] cap_hdr_value;

    // Byte enables widen to a bit mask so partial writes leave other lanes.
    assign be_mask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}},
                      {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
    assign cfg_we  = i_cfg_wr & i_clock_en;

    // Implemented positions
    // Only implemented positions ever latch; others stay zero.
    assign unc_new = i_unc_event & `AER_UNC_IMPL;

    assign unc_unmasked = unc_new & ~unc_mask_reg;

    assign cor_unmasked = i_cor_event & `AER_COR_IMPL & ~cor_mask_reg;

    assign cap_hdr_value = {`AER_NEXT_CAP_OFFSET, `AER_CAP_VERSION, `AER_CAP_ID};

    assign ctrl_value = {23'h000000, ecrc_chk_en_reg, `AER_ECRC_CHK_CAP,
                         ecrc_gen_en_reg, `AER_ECRC_GEN_CAP, first_ptr_reg};

    assign o_ecrc_gen_en   = ecrc_gen_en_reg;
    assign o_ecrc_check_en = ecrc_chk_en_reg;

    ////////////////////////////////////////////////////////////////////////
    // First error selection.

    // The lowest unmasked new error wins when several arrive together,
    // since the pointer can only name one position.
    always @* begin
        low_pos   = 5'h00;
        low_found = 1'b0;
        for (idx = 31; idx >= 0; idx = idx - 1) begin
            if (unc_unmasked[idx]) begin
                low_pos   = idx[4:0];
                low_found = 1'b1;
            end
        end
    end

    // Capture only if idle
    // The pointer is free when its status bit has been cleared; the reset
    // value 1fh names a position that never sets, so it counts as free.
    assign log_take = low_found & ~unc_status_reg[first_ptr_reg];

    ////////////////////////////////////////////////////////////////////////
    // Status next values.

    // Hardware set wins over a software clear in the same cycle, so an
    // error landing on the clear write is never lost.
    always @* begin
        unc_status_next = unc_status_reg;
        cor_status_next = cor_status_reg;
        first_ptr_next  = first_ptr_reg;
        if (cfg_we && i_cfg_addr == `AER_OFF_UNC_STATUS) begin
            unc_status_next = unc_status_next
                              & ~(i_cfg_wdata & be_mask & `AER_UNC_IMPL);
        end
        if (cfg_we && i_cfg_addr == `AER_OFF_COR_STATUS) begin
            cor_status_next = cor_status_next
                              & ~(i_cfg_wdata & be_mask & `AER_COR_IMPL);
        end
        unc_status_next = unc_status_next | unc_new;
        cor_status_next = cor_status_next | (i_cor_event & `AER_COR_IMPL);
        if (log_take) begin
            first_ptr_next = low_pos;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status, pointer and header log.

    // Fundamental reset only
    // Hot and link-down resets never reach this block, so every field here
    // is sticky by construction.
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            unc_status_reg <= `AER_UNC_STATUS_RST;
            cor_status_reg <= `AER_COR_STATUS_RST;
            first_ptr_reg  <= `AER_FIRST_PTR_RST;
            hdr_log0_reg   <= `AER_HDR_LOG_RST;
            hdr_log1_reg   <= `AER_HDR_LOG_RST;
            hdr_log2_reg   <= `AER_HDR_LOG_RST;
            hdr_log3_reg   <= `AER_HDR_LOG_RST;
        end else if (i_clock_en) begin
            unc_status_reg <= unc_status_next;
            cor_status_reg <= cor_status_next;
            first_ptr_reg  <= first_ptr_next;
            if (log_take) begin
                hdr_log0_reg <= i_tlp_header[31:0];
                hdr_log1_reg <= i_tlp_header[63:32];
                hdr_log2_reg <= i_tlp_header[95:64];
                hdr_log3_reg <= i_tlp_header[127:96];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky read-write fields.

    // Configuration writes take precedence over a preload in the same
    // cycle; the preload runs before enumeration, so they should not meet.
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            unc_mask_reg    <= `AER_UNC_MASK_RST;
            unc_sev_reg     <= `AER_UNC_SEV_RST;
            cor_mask_reg    <= `AER_COR_MASK_RST;
            ecrc_gen_en_reg <= `AER_ECRC_GEN_EN_RST;
            ecrc_chk_en_reg <= `AER_ECRC_CHK_EN_RST;
        end else if (i_clock_en) begin
            if (i_cfg_wr) begin
                case (i_cfg_addr)
                    `AER_OFF_UNC_MASK: begin
                        unc_mask_reg <= (unc_mask_reg & ~(be_mask & `AER_UNC_IMPL))
                                        | (i_cfg_wdata & be_mask & `AER_UNC_IMPL);
                    end
                    `AER_OFF_UNC_SEVERITY: begin
                        unc_sev_reg <= (unc_sev_reg & ~(be_mask & `AER_UNC_IMPL))
                                       | (i_cfg_wdata & be_mask & `AER_UNC_IMPL);
                    end
                    `AER_OFF_COR_MASK: begin
                        cor_mask_reg <= (cor_mask_reg & ~(be_mask & `AER_COR_IMPL))
                                        | (i_cfg_wdata & be_mask & `AER_COR_IMPL);
                    end
                    `AER_OFF_CAP_CTRL: begin
                        if (i_cfg_be[0]) begin
                            ecrc_gen_en_reg <= i_cfg_wdata[`AER_CTRL_GEN_EN];
                        end
                        if (i_cfg_be[1]) begin
                            ecrc_chk_en_reg <= i_cfg_wdata[`AER_CTRL_CHK_EN];
                        end
                    end
                    default: begin
                        ecrc_gen_en_reg <= ecrc_gen_en_reg;
                    end
                endcase
            end else if (i_load_wr) begin
                case (i_load_addr)
                    `AER_OFF_UNC_MASK: begin
                        unc_mask_reg <= i_load_data & `AER_UNC_IMPL;
                    end
                    `AER_OFF_UNC_SEVERITY: begin
                        // Keep reserved default
                        // Bit 13 is not loadable, so it keeps its reset value of one.
                        unc_sev_reg <= (i_load_data & `AER_UNC_IMPL)
                                       | (`AER_UNC_SEV_RST & ~`AER_UNC_IMPL);
                    end
                    `AER_OFF_COR_MASK: begin
                        cor_mask_reg <= i_load_data & `AER_COR_IMPL;
                    end
                    `AER_OFF_CAP_CTRL: begin
                        ecrc_gen_en_reg <= i_load_data[`AER_CTRL_GEN_EN];
                        ecrc_chk_en_reg <= i_load_data[`AER_CTRL_CHK_EN];
                    end
                    default: begin
                        ecrc_chk_en_reg <= ecrc_chk_en_reg;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error message pulses.

    // One registered pulse per message class per cycle with any unmasked
    // detection; simultaneous errors of one class merge into one pulse.
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_report_fatal       <= 1'b0;
            o_report_nonfatal    <= 1'b0;
            o_report_correctable <= 1'b0;
        end else if (i_clock_en) begin
            o_report_fatal       <= |(unc_unmasked & unc_sev_reg);
            o_report_nonfatal    <= |(unc_unmasked & ~unc_sev_reg);
            o_report_correctable <= |cor_unmasked;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration read data.

    // Read data is registered; it appears one edge after the read strobe
    // and holds until the next read. Unmapped offsets read zero.
    always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cfg_rdata <= 32'h00000000;
        end else if (i_clock_en && i_cfg_rd) begin
            case (i_cfg_addr)
                `AER_OFF_CAP_HDR:      o_cfg_rdata <= cap_hdr_value;
                `AER_OFF_UNC_STATUS:   o_cfg_rdata <= unc_status_reg;
                `AER_OFF_UNC_MASK:     o_cfg_rdata <= unc_mask_reg;
                `AER_OFF_UNC_SEVERITY: o_cfg_rdata <= unc_sev_reg;
                `AER_OFF_COR_STATUS:   o_cfg_rdata <= cor_status_reg;
                `AER_OFF_COR_MASK:     o_cfg_rdata <= cor_mask_reg;
                `AER_OFF_CAP_CTRL:     o_cfg_rdata <= ctrl_value;
                `AER_OFF_HDR_LOG0:     o_cfg_rdata <= hdr_log0_reg;
                `AER_OFF_HDR_LOG1:     o_cfg_rdata <= hdr_log1_reg;
                `AER_OFF_HDR_LOG2:     o_cfg_rdata <= hdr_log2_reg;
                `AER_OFF_HDR_LOG3:     o_cfg_rdata <= hdr_log3_reg;
                default:               o_cfg_rdata <= 32'h00000000;
            endcase
        end
    end

endmodule

/* verification/aer_err_src.sv */
// Model of the layer error detectors that feed the bank.
// Assumes the bench raises i_fire off the rising edge for one cycle.
`timescale 1ns/1ps
module aer_err_src (
    input  wire         i_clock,
    input  wire         i_fire,
    input  wire [31:0]  i_unc,
    input  wire [31:0]  i_cor,
    input  wire [127:0] i_hdr,
    output wire [31:0]  o_unc_event,
    output wire [31:0]  o_cor_event,
    output wire [127:0] o_tlp_header
);
    reg [127:0] junk_reg = 128'h0;
    // The header bus churns between events, so a late capture shows up.
    always @(posedge i_clock) begin
        junk_reg <= ~junk_reg ^ {4{junk_reg[31:0] + 32'h9e37}};
    end
    // Pulses last exactly as long as the bench holds i_fire.
    assign o_unc_event  = i_fire ? i_unc : 32'h0;
    assign o_cor_event  = i_fire ? i_cor : 32'h0;
    assign o_tlp_header = i_fire ? i_hdr : junk_reg;
endmodule

/* verification/aer_bank_monitor.sv */
// Port assertions for the error reporting bank.
// Assumes a bind onto aer_bank and a single clock domain.
`timescale 1ns/1ps
`include "aer_consts.vh"
module aer_bank_monitor (
    input wire        i_clock,
    input wire        i_resetn,
    input wire        i_clock_en,
    input wire [11:0] i_cfg_addr,
    input wire        i_cfg_wr,
    input wire        i_cfg_rd,
    input wire [3:0]  i_cfg_be,
    input wire [31:0] i_cfg_wdata,
    input wire [31:0] o_cfg_rdata,
    input wire [31:0] i_unc_event,
    input wire [31:0] i_cor_event,
    input wire        o_report_fatal,
    input wire        o_report_correctable,
    input wire        o_ecrc_gen_en,
    input wire        o_ecrc_check_en
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////////////////
    // Steps of a full status clear, a status read and a control write.
    sequence s_clr_all;
        i_clock_en && i_cfg_wr && i_cfg_addr == `AER_OFF_UNC_STATUS && i_cfg_be == 4'hf
            && i_cfg_wdata == 32'hffffffff && i_unc_event == 32'h0;
    endsequence
    sequence s_rd_unc;
        i_clock_en && i_cfg_rd && i_cfg_addr == `AER_OFF_UNC_STATUS && i_unc_event == 32'h0;
    endsequence
    sequence s_ctrl_wr;
        i_clock_en && i_cfg_wr && i_cfg_addr == `AER_OFF_CAP_CTRL;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_fatal_cause: assert property (
        o_report_fatal |-> $past(i_clock_en && (i_unc_event & `AER_UNC_IMPL) != 32'h0))
        else $error("fatal report without an event");
    a_fatal_pulse: assert property (
        o_report_fatal && i_clock_en && i_unc_event == 32'h0 |=> !o_report_fatal)
        else $error("fatal report longer than one cycle");
    a_cor_cause: assert property (
        o_report_correctable |-> $past(i_clock_en && (i_cor_event & `AER_COR_IMPL) != 32'h0))
        else $error("correctable report without an event");
    a_gen_write: assert property (
        s_ctrl_wr ##0 i_cfg_be[0] |=> o_ecrc_gen_en == $past(i_cfg_wdata[`AER_CTRL_GEN_EN]))
        else $error("generation enable not written");
    a_chk_write: assert property (
        s_ctrl_wr ##0 i_cfg_be[1] |=> o_ecrc_check_en == $past(i_cfg_wdata[`AER_CTRL_CHK_EN]))
        else $error("checking enable not written");
    a_hdr_read: assert property (
        i_clock_en && i_cfg_rd && i_cfg_addr == `AER_OFF_CAP_HDR |=>
            o_cfg_rdata == {`AER_NEXT_CAP_OFFSET, `AER_CAP_VERSION, `AER_CAP_ID})
        else $error("capability header wrong");
    a_rdata_hold: assert property (
        !(i_clock_en && i_cfg_rd) |=> $stable(o_cfg_rdata))
        else $error("read data moved without a read");
    a_blank_read: assert property (
        i_clock_en && i_cfg_rd && i_cfg_addr > `AER_OFF_HDR_LOG3 |=> o_cfg_rdata == 32'h0)
        else $error("reserved offset read not zero");
    a_w1c_clear: assert property (
        s_clr_all ##1 i_unc_event == 32'h0 ##1 s_rd_unc |=> o_cfg_rdata == 32'h0)
        else $error("status not cleared by ones");
endmodule

/* verification/tb_aer_bank.sv */
// Self-checking bench for the error reporting bank.
// Assumes the detector model and the port checker are compiled before it.
`timescale 1ns/1ps
`include "aer_consts.vh"
module tb_aer_bank;
    reg          clock     = 1'b0;
    reg          resetn    = 1'b0;
    reg  [11:0]  addr      = 12'h0;
    reg          wr        = 1'b0;
    reg          rd        = 1'b0;
    reg  [3:0]   be        = 4'h0;
    reg  [31:0]  wdata     = 32'h0;
    reg          load_wr   = 1'b0;
    reg  [11:0]  load_addr = 12'h0;
    reg  [31:0]  load_data = 32'h0;
    reg          fire      = 1'b0;
    reg          clk_en    = 1'b1;
    reg  [31:0]  unc       = 32'h0;
    reg  [31:0]  cor       = 32'h0;
    reg  [127:0] hdr       = 128'h0;
    reg  [127:0] hsave;
    reg  [31:0]  seed      = 32'h4010c99e;
    reg  [31:0]  rv;
    reg  [2:0]   rep;
    reg  [4:0]   pos [0:12];
    wire [31:0]  rdata, unc_ev, cor_ev;
    wire [127:0] tlp;
    wire         fatal, nonfatal, corr, gen_en, chk_en;
    integer      error_cnt = 0;
    integer      tests_run = 0;
    integer      cycles    = 0;
    integer      i;
    aer_bank i_dut (.i_clock(clock), .i_resetn(resetn), .i_clock_en(clk_en), .i_cfg_addr(addr),
        .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
        .i_load_wr(load_wr), .i_load_addr(load_addr), .i_load_data(load_data),
        .i_unc_event(unc_ev), .i_cor_event(cor_ev), .i_tlp_header(tlp),
        .o_report_fatal(fatal), .o_report_nonfatal(nonfatal), .o_report_correctable(corr),
        .o_ecrc_gen_en(gen_en), .o_ecrc_check_en(chk_en));
    aer_err_src i_src (.i_clock(clock), .i_fire(fire), .i_unc(unc), .i_cor(cor), .i_hdr(hdr),
        .o_unc_event(unc_ev), .o_cor_event(cor_ev), .o_tlp_header(tlp));
    ////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling well above the expected run of about 160.
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 4000) begin
            error_cnt = error_cnt + 1;
            stop_test;
        end
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input string n, input [31:0] e, input [31:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("ERROR %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    // One access; the idle cycle after it keeps strobes from toggling twice.
    task acc(input w, input [11:0] a, input [31:0] d, input [3:0] b);
        begin
            wr = w;
            rd = !w;
            addr = a;
            wdata = d;
            be = b;
            @(negedge clock);
            rv = rdata;
            wr = 1'b0;
            rd = 1'b0;
            @(negedge clock);
        end
    endtask
    task ld(input [11:0] a, input [31:0] d);
        begin
            load_wr = 1'b1;
            load_addr = a;
            load_data = d;
            @(negedge clock);
            load_wr = 1'b0;
            @(negedge clock);
        end
    endtask
    // Reports stand for the one cycle after the event cycle.
    task ev(input [31:0] u, input [31:0] c);
        begin
            fire = 1'b1;
            unc = u;
            cor = c;
            @(negedge clock);
            rep = {fatal, nonfatal, corr};
            fire = 1'b0;
            @(negedge clock);
        end
    endtask
    task defaults;
        begin
            for (i = 0; i < 12; i = i + 1) begin
                acc(1'b0, 12'hfb4 + i * 4, 32'h0, 4'h0);
                chk("default", i == 0 ? 32'h13810001 : i == 3 ? 32'h00062030 :
                    i == 6 ? 32'h000000bf : 32'h0, rv);
            end
            $display("test defaults done");
        end
    endtask
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", tests_run, error_cnt);
            if (error_cnt == 0 && tests_run > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence: capture, severity, masks, correctable, ECRC, reset.
    initial begin
        {pos[0], pos[1], pos[2], pos[3], pos[4], pos[5], pos[6]} = {5'd4, 5'd5, 5'd12,
            5'd16, 5'd17, 5'd18, 5'd19};
        {pos[7], pos[8], pos[9], pos[10], pos[11], pos[12]} = {5'd20, 5'd0, 5'd6, 5'd7,
            5'd8, 5'd12};
        repeat (20) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        defaults;
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr(seed);
            hdr[32 * i +: 32] = seed;
        end
        hsave = hdr;
        ev(32'h00040000, 32'h0);
        chk("fatal", 32'h4, rep);
        acc(1'b0, `AER_OFF_CAP_CTRL, 32'h0, 4'h0);
        chk("pointer", 32'hb2, rv);
        for (i = 0; i < 4; i = i + 1) begin
            acc(1'b0, `AER_OFF_HDR_LOG0 + i * 4, 32'h0, 4'h0);
            chk("log", hsave[32 * i +: 32], rv);
        end
        hdr = ~hdr;
        ev(32'h00001000, 32'h0);
        chk("nonfatal", 32'h2, rep);
        acc(1'b0, `AER_OFF_UNC_STATUS, 32'h0, 4'h0);
        chk("status", 32'h00041000, rv);
        acc(1'b0, `AER_OFF_CAP_CTRL, 32'h0, 4'h0);
        chk("pointer", 32'hb2, rv);
        acc(1'b0, `AER_OFF_HDR_LOG0, 32'h0, 4'h0);
        chk("log", hsave[31:0], rv);
        acc(1'b1, `AER_OFF_UNC_STATUS, 32'hffffffff, 4'hf);
        acc(1'b0, `AER_OFF_UNC_STATUS, 32'h0, 4'h0);
        chk("status", 32'h0, rv);
        $display("test capture done");
        seed = lfsr(seed);
        ld(`AER_OFF_UNC_SEVERITY, seed);
        acc(1'b0, `AER_OFF_UNC_SEVERITY, 32'h0, 4'h0);
        chk("severity", (seed & 32'h001f1030) | 32'h00002000, rv);
        hsave = hdr;
        for (i = 0; i < 8; i = i + 1) begin
            ev(32'h1 << pos[i], 32'h0);
            chk("class", {seed[pos[i]], ~seed[pos[i]], 1'b0}, rep);
        end
        acc(1'b0, `AER_OFF_UNC_STATUS, 32'h0, 4'h0);
        chk("status", 32'h001f1030, rv);
        acc(1'b0, `AER_OFF_CAP_CTRL, 32'h0, 4'h0);
        chk("pointer", 32'ha4, rv);
        acc(1'b0, `AER_OFF_HDR_LOG0, 32'h0, 4'h0);
        chk("log", hsave[31:0], rv);
        acc(1'b1, `AER_OFF_UNC_MASK, 32'hffffffff, 4'hf);
        acc(1'b0, `AER_OFF_UNC_MASK, 32'h0, 4'h0);
        chk("mask", 32'h001f1030, rv);
        acc(1'b1, `AER_OFF_UNC_STATUS, 32'hffffffff, 4'hf);
        ev(32'h20, 32'h0);
        chk("masked", 32'h0, rep);
        acc(1'b0, `AER_OFF_UNC_STATUS, 32'h0, 4'h0);
        chk("status", 32'h20, rv);
        acc(1'b0, `AER_OFF_CAP_CTRL, 32'h0, 4'h0);
        chk("pointer", 32'ha4, rv);
        acc(1'b1, `AER_OFF_UNC_MASK, 32'h0, 4'hf);
        $display("test uncorrectable done");
        acc(1'b1, `AER_OFF_COR_MASK, 32'h40, 4'h1);
        for (i = 8; i < 13; i = i + 1) begin
            ev(32'h0, 32'h1 << pos[i]);
            chk("cor", pos[i] != 5'd6, rep);
        end
        acc(1'b0, `AER_OFF_COR_STATUS, 32'h0, 4'h0);
        chk("cor status", 32'h000011c1, rv);
        $display("test correctable done");
        acc(1'b1, `AER_OFF_CAP_CTRL, 32'h1ff, 4'h1);
        chk("ecrc", 32'h2, {gen_en, chk_en});
        acc(1'b1, `AER_OFF_CAP_CTRL, 32'h100, 4'h2);
        chk("ecrc", 32'h3, {gen_en, chk_en});
        acc(1'b0, `AER_OFF_CAP_CTRL, 32'h0, 4'h0);
        chk("ctrl", 32'h1e4, rv);
        ld(`AER_OFF_CAP_CTRL, 32'h0);
        chk("ecrc", 32'h0, {gen_en, chk_en});
        $display("test ecrc done");
        // A frozen clock enable must drop an event: no report and no status change.
        clk_en = 1'b0;
        ev(32'h00100000, 32'h0);
        chk("frozen", 32'h0, rep);
        clk_en = 1'b1;
        acc(1'b0, `AER_OFF_UNC_STATUS, 32'h0, 4'h0);
        chk("frozen status", 32'h20, rv);
        $display("test freeze done");
        resetn = 1'b0;
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        defaults;
        stop_test;
    end
endmodule
bind aer_bank aer_bank_monitor i_mon (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_clock_en(i_clock_en), .i_cfg_addr(i_cfg_addr), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
    .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata),
    .i_unc_event(i_unc_event), .i_cor_event(i_cor_event), .o_report_fatal(o_report_fatal),
    .o_report_correctable(o_report_correctable), .o_ecrc_gen_en(o_ecrc_gen_en),
    .o_ecrc_check_en(o_ecrc_check_en));
